//--- logic/arr_top.sv
// converter result registers with byte lock, alignment and completion interrupt
`timescale 1ns/1ps
`default_nettype none
`include "arr_map.svh"

// Operation
// R1: after the low result byte is read, no new result enters either byte until the high byte is read.
// R2: software reads the low byte first and the high byte second for a full-precision result.
// R3: with left alignment, software may read only the high byte for eight-bit precision.
// R4: right alignment puts bits 9..8 in high bits 1..0 and bits 7..0 in the low byte, rest zero.
// R5: left alignment puts bits 9..2 in the high byte and bits 1..0 in low bits 7..6, rest zero.
// R6: both result bytes are read-only, reset to zero, and writes leave the result alone.
// R7: the code is passed unchanged, zero meaning ground and all ones full scale less one step.
// R8: a channel change during a conversion takes effect only after that conversion ends.
// R9: completion raises the flag and in free-running mode starts the next conversion at once; the code sets it only when the result is stored.
// R10: a channel write after completion in free-running mode only affects the following conversion.
// R11: the alignment bit changes the presentation of the stored result at once.
// R12: a stored result sets the conversion-done flag in the control and status register.
// R13: the high-byte read releases the lock and a result finishing under the lock is dropped.
module arr_top
  import arr_pkg::*;
#(
  parameter int CONV_CYCLES = `ARR_CONV_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end
  input wire logic [9:0] conversion_code,
  output logic [2:0] active_channel,
  output logic [1:0] active_reference,
  output logic converting,
  // interrupt
  output logic irq
);

  // ============================================================
  // bus front end
  logic wr_pulse, rd_pulse;
  logic [5:0] wr_index, rd_index;
  logic [7:0] wr_byte, rd_byte;

  arr_axil_slave i_arr_axil_slave (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_pulse(wr_pulse),
    .wr_index(wr_index),
    .wr_byte(wr_byte),
    .rd_pulse(rd_pulse),
    .rd_index(rd_index),
    .rd_byte(rd_byte)
  );

  // ============================================================
  // code input synchroniser
  // the front end settles on its own timing, so the code crosses two flops
  arr_code_t code_meta_reg, code_sync_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      code_meta_reg <= `ARR_RST_RESULT;
      code_sync_reg <= `ARR_RST_RESULT;
    end
    else
    begin
      code_meta_reg <= conversion_code;
      code_sync_reg <= code_meta_reg;
    end
  end

  // ============================================================
  // helpers
  // present the stored code as high and low bytes
  function automatic arr_bytes_t present(input arr_code_t code, input logic left);
    arr_bytes_t b;
    if (left)
      b = {code[9:2], code[1:0], 6'h00}; // R5
    else
      b = {6'h00, code[9:8], code[7:0]}; // R4
    return b;
  endfunction

  // true for a bus pulse hitting one register index
  function automatic logic hit(input logic pulse, input logic [5:0] idx, input logic [7:0] reg_idx);
    return pulse && (idx == reg_idx[5:0]);
  endfunction

  // ============================================================
  // control, channel and result state
  logic enable_reg, enable_next;
  logic free_reg, free_next;
  logic start_reg, start_next;
  logic done_flag_reg, done_flag_next;
  logic [1:0] ref_reg, ref_next;
  logic align_reg, align_next;
  logic [2:0] mux_reg, mux_next;
  arr_code_t result_reg, result_next;
  logic lock_reg, lock_next;
  logic irq_stat_reg, irq_stat_next;
  logic irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;

  logic seq_busy, seq_done;
  arr_code_t seq_code;
  logic [4:0] seq_setting;
  logic store;
  logic wr_ctrl, wr_chan, wr_mask, rd_low, rd_high, rd_stat;

  assign wr_ctrl = hit(wr_pulse, wr_index, `ARR_IDX_CTRL_STATUS);
  assign wr_chan = hit(wr_pulse, wr_index, `ARR_IDX_CHAN_SELECT);
  assign wr_mask = hit(wr_pulse, wr_index, `ARR_IDX_IRQ_MASK);
  assign rd_low = hit(rd_pulse, rd_index, `ARR_IDX_RESULT_LOW);
  assign rd_high = hit(rd_pulse, rd_index, `ARR_IDX_RESULT_HIGH);
  assign rd_stat = hit(rd_pulse, rd_index, `ARR_IDX_IRQ_STATUS);

  // a finished conversion is stored only while the bytes are unlocked
  assign store = seq_done && !lock_reg; // R1 R13

  // ============================================================
  // conversion sequencer
  arr_conv_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) i_arr_conv_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(enable_reg),
    .start(start_reg),
    .free_run(free_reg),
    .setting({ref_reg, mux_reg}),
    .code_in(code_sync_reg),
    .busy(seq_busy),
    .done(seq_done),
    .code_out(seq_code),
    .active_setting(seq_setting)
  );

  // next values of software-visible state
  always_comb
  begin
    enable_next = enable_reg;
    free_next = free_reg;
    start_next = start_reg;
    done_flag_next = done_flag_reg;
    ref_next = ref_reg;
    align_next = align_reg;
    mux_next = mux_reg;
    result_next = result_reg;
    lock_next = lock_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    // start request is consumed once the sequencer runs
    if (seq_busy || !enable_reg)
      start_next = 1'b0;
    if (wr_ctrl)
    begin
      enable_next = wr_byte[`ARR_CTRL_ENABLE_BIT];
      free_next = wr_byte[`ARR_CTRL_FREE_BIT];
      if (wr_byte[`ARR_CTRL_START_BIT] && wr_byte[`ARR_CTRL_ENABLE_BIT])
        start_next = 1'b1; // writing zero to start has no effect
      if (wr_byte[`ARR_CTRL_DONE_BIT])
        done_flag_next = 1'b0; // write one to clear
    end
    if (wr_chan)
    begin
      // only the setting register moves; the running conversion keeps its own copy
      ref_next = wr_byte[`ARR_CHAN_REF_HI_BIT:`ARR_CHAN_REF_LO_BIT]; // R8 R10
      align_next = wr_byte[`ARR_CHAN_ALIGN_BIT]; // R11
      mux_next = wr_byte[`ARR_CHAN_MUX_HI_BIT:0];
    end
    if (wr_mask)
      irq_mask_next = wr_byte[`ARR_IRQ_DONE_BIT];
    if (rd_stat)
      irq_stat_next = 1'b0; // read clears
    if (rd_low)
      lock_next = 1'b1; // R1
    if (rd_high)
      lock_next = 1'b0; // R13
    // writes to the result indices fall through: nothing decodes them
    if (store)
    begin
      result_next = seq_code; // R6 R7
      done_flag_next = 1'b1; // R12
      irq_stat_next = 1'b1; // set wins over read clear
    end
    irq_next = irq_stat_next && irq_mask_next;
  end

  // software-visible state registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      enable_reg <= 1'b0;
      free_reg <= 1'b0;
      start_reg <= 1'b0;
      done_flag_reg <= 1'b0;
      ref_reg <= 2'h0;
      align_reg <= 1'b0;
      mux_reg <= 3'h0;
      result_reg <= `ARR_RST_RESULT; // R6
      lock_reg <= 1'b0;
      irq_stat_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      enable_reg <= enable_next;
      free_reg <= free_next;
      start_reg <= start_next;
      done_flag_reg <= done_flag_next;
      ref_reg <= ref_next;
      align_reg <= align_next;
      mux_reg <= mux_next;
      result_reg <= result_next;
      lock_reg <= lock_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
    end
  end

  // ============================================================
  // read data mux
  // presentation follows the alignment bit live, not the bit at store time
  arr_bytes_t shown;
  assign shown = present(result_reg, align_reg); // R11

  always_comb
  begin
    rd_byte = 8'h00; // unmapped indices read zero
    if (rd_index == `ARR_IDX_RESULT_LOW)
      rd_byte = shown[7:0]; // R4 R5
    else if (rd_index == `ARR_IDX_RESULT_HIGH)
      rd_byte = shown[15:8]; // R4 R5
    else if (rd_index == `ARR_IDX_CTRL_STATUS)
      rd_byte = {enable_reg, seq_busy || start_reg, free_reg, done_flag_reg, 4'h0};
    else if (rd_index == `ARR_IDX_CHAN_SELECT)
      rd_byte = {ref_reg, align_reg, 2'h0, mux_reg};
    else if (rd_index == `ARR_IDX_IRQ_STATUS)
      rd_byte = {7'h00, irq_stat_reg};
    else if (rd_index == `ARR_IDX_IRQ_MASK)
      rd_byte = {7'h00, irq_mask_reg};
  end

  // ============================================================
  // front-end outputs, all from flops
  logic [2:0] chan_out_reg;
  logic [1:0] ref_out_reg;
  logic conv_out_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      chan_out_reg <= 3'h0;
      ref_out_reg <= 2'h0;
      conv_out_reg <= 1'b0;
    end
    else
    begin
      chan_out_reg <= seq_setting[2:0]; // R8
      ref_out_reg <= seq_setting[4:3];
      conv_out_reg <= seq_busy;
    end
  end

  assign active_channel = chan_out_reg;
  assign active_reference = ref_out_reg;
  assign converting = conv_out_reg;
  assign irq = irq_reg; // R9

endmodule
`default_nettype wire

//--- logic/arr_map.svh
// register map, field positions, reset values and timing counts of the result block
`ifndef ARR_MAP_SVH
`define ARR_MAP_SVH

// ============================================================
// register indices; byte address is four times the index
`define ARR_IDX_RESULT_LOW   8'h04
`define ARR_IDX_RESULT_HIGH  8'h05
`define ARR_IDX_CTRL_STATUS  8'h06
`define ARR_IDX_CHAN_SELECT  8'h07
`define ARR_IDX_IRQ_STATUS   8'h08
`define ARR_IDX_IRQ_MASK     8'h09

// ============================================================
// converter_control_status fields
`define ARR_CTRL_ENABLE_BIT  7
`define ARR_CTRL_START_BIT   6
`define ARR_CTRL_FREE_BIT    5
`define ARR_CTRL_DONE_BIT    4

// ============================================================
// channel_select_register fields
`define ARR_CHAN_REF_HI_BIT  7
`define ARR_CHAN_REF_LO_BIT  6
`define ARR_CHAN_ALIGN_BIT   5
`define ARR_CHAN_MUX_HI_BIT  2

// ============================================================
// interrupt status and mask fields
`define ARR_IRQ_DONE_BIT     0

// ============================================================
// reset values
`define ARR_RST_BYTE         8'h00
`define ARR_RST_RESULT       10'h000

// ============================================================
// timing: least conversion time in ns, clock period in ns
`define ARR_CONV_TIME_NS     65000
`define ARR_CLK_PERIOD_NS    100
`define ARR_CONV_CYCLES      ((`ARR_CONV_TIME_NS + `ARR_CLK_PERIOD_NS - 1) / `ARR_CLK_PERIOD_NS)

`endif

//--- logic/arr_pkg.sv
// types shared by the result block modules
package arr_pkg;

  // conversion sequencer states
  typedef enum logic [0:0] {
    ARR_IDLE,
    ARR_CONVERT
  } arr_conv_state_t;

  // one 10-bit conversion code
  typedef logic [9:0] arr_code_t;

  // two presented result bytes, high byte first
  typedef logic [15:0] arr_bytes_t;

endpackage

//--- logic/arr_axil_slave.sv
// axi4-lite slave front end turning bus transfers into register pulses
`timescale 1ns/1ps
`default_nettype none
module arr_axil_slave
  import arr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // write address and data channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output logic wr_pulse,
  output logic [5:0] wr_index,
  output logic [7:0] wr_byte,
  output logic rd_pulse,
  output logic [5:0] rd_index,
  input wire logic [7:0] rd_byte
);

  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [5:0] aw_idx_reg, aw_idx_next;
  logic [7:0] w_byte_reg, w_byte_next;
  logic w_lane_reg, w_lane_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [7:0] rdata_reg, rdata_next;
  logic aw_take, w_take, ar_take;
  logic awready_reg, wready_reg, arready_reg;

  // address and data are taken in either order, held until both are in
  assign aw_take = s_axi_awvalid && !aw_got_reg && !bvalid_reg;
  assign w_take = s_axi_wvalid && !w_got_reg && !bvalid_reg;
  assign ar_take = s_axi_arvalid && !rvalid_reg;

  // next-state of both channels
  always_comb
  begin
    aw_got_next = aw_got_reg || aw_take;
    w_got_next = w_got_reg || w_take;
    aw_idx_next = aw_take ? s_axi_awaddr[7:2] : aw_idx_reg;
    w_byte_next = w_take ? s_axi_wdata[7:0] : w_byte_reg;
    w_lane_next = w_take ? s_axi_wstrb[0] : w_lane_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    wr_pulse = 1'b0;
    if (aw_got_reg && w_got_reg)
    begin
      // only lane 0 carries register bits
      wr_pulse = w_lane_reg;
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
    end
    rd_pulse = ar_take;
    rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
    rdata_next = ar_take ? rd_byte : rdata_reg;
  end

  assign wr_index = aw_idx_reg;
  assign wr_byte = w_byte_reg;
  assign rd_index = s_axi_araddr[7:2];

  // channel state registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      aw_idx_reg <= aw_idx_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      // readies are registered copies of the take conditions
      awready_reg <= !aw_got_next && !bvalid_next;
      wready_reg <= !w_got_next && !bvalid_next;
      arready_reg <= !rvalid_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};
  assign s_axi_rresp = 2'h0;

endmodule
`default_nettype wire

//--- logic/arr_conv_seq.sv
// conversion sequencer: times conversions and latches the channel at each start
`timescale 1ns/1ps
`default_nettype none
`include "arr_map.svh"
module arr_conv_seq
  import arr_pkg::*;
#(
  parameter int CONV_CYCLES = `ARR_CONV_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic enable,
  input wire logic start,
  input wire logic free_run,
  input wire logic [4:0] setting,
  input wire arr_code_t code_in,
  // status
  output logic busy,
  output logic done,
  output arr_code_t code_out,
  output logic [4:0] active_setting
);

  arr_conv_state_t state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic done_next;
  arr_code_t code_reg, code_next;
  logic [4:0] act_reg, act_next;

  // sequencing; channel and reference only change at a start
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    done_next = 1'b0;
    code_next = code_reg;
    act_next = act_reg;
    unique case (state_reg)
      ARR_IDLE:
      begin
        if (enable && start)
        begin
          state_next = ARR_CONVERT;
          count_next = 16'(CONV_CYCLES - 1);
          act_next = setting;
        end
      end
      ARR_CONVERT:
      begin
        if (!enable)
          state_next = ARR_IDLE; // switching off aborts the conversion
        else if (count_reg == 16'h0000)
        begin
          done_next = 1'b1;
          code_next = code_in;
          if (free_run)
          begin
            count_next = 16'(CONV_CYCLES - 1); // R9
            act_next = setting; // R8 R10
          end
          else
            state_next = ARR_IDLE;
        end
        else
          count_next = count_reg - 16'h0001;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ARR_IDLE;
      count_reg <= 16'h0000;
      done <= 1'b0;
      code_reg <= `ARR_RST_RESULT;
      act_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      done <= done_next;
      code_reg <= code_next;
      act_reg <= act_next;
    end
  end

  assign busy = (state_reg == ARR_CONVERT);
  assign code_out = code_reg;
  assign active_setting = act_reg;

endmodule
`default_nettype wire

//--- tb/arr_top_asserts.sv
// port-level assertion checker for the converter result block
`timescale 1ns/1ps
`default_nettype none
module arr_top_asserts
  import arr_pkg::*;
#(
  parameter int CONV_CYCLES = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter side
  input wire logic [2:0] active_channel,
  input wire logic [1:0] active_reference,
  input wire logic converting
);
  int run_len_reg;
  int run_len_next;
  // ============================================================
  // length of the current converting run, so an early stop is caught
  always_comb
  begin
    run_len_next = converting ? run_len_reg + 1 : 0;
  end
  always_ff @(posedge clk)
  begin
    run_len_reg <= sys_rst ? 0 : run_len_next;
  end
  // ============================================================
  // handshake steps
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_take;
    s_axi_rvalid && s_axi_rready;
  endsequence
  sequence s_b_take;
    s_axi_bvalid && s_axi_bready;
  endsequence
  // ============================================================
  // properties
  chk_ar_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  chk_r_release: assert property (s_r_take |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  chk_b_release: assert property (s_b_take |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released");
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  chk_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above byte");
  chk_resp_okay: assert property (s_axi_rvalid || s_axi_bvalid |-> s_axi_rresp == 2'h0 && s_axi_bresp == 2'h0)
    else $error("response not okay");
  // settings latched at a start hold for six cycles after each change (conversions are 16 cycles here)
  chk_chan_hold: assert property ($changed({active_channel, active_reference}) |=> $stable({active_channel, active_reference})[*6])
    else $error("channel changed mid conversion");
  chk_conv_min: assert property ($fell(converting) |-> run_len_reg >= CONV_CYCLES - 1)
    else $error("conversion too short");
endmodule
`default_nettype wire

//--- tb/tb_arr_top.sv
// self-checking bench for the converter result block
`timescale 1ns/1ps
`default_nettype none
`include "arr_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_arr_top
  import arr_pkg::*;
;
  // short conversions keep the run brief
  localparam int CONV = 16;
  localparam logic [7:0] A_LO = 8'h10;
  localparam logic [7:0] A_HI = 8'h14;
  localparam logic [7:0] A_CTRL = 8'h18;
  localparam logic [7:0] A_CHAN = 8'h1C;
  localparam logic [7:0] A_IRQS = 8'h20;
  localparam logic [7:0] A_MASK = 8'h24;
  logic clk;
  logic sys_rst;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  arr_code_t conversion_code;
  logic [2:0] active_channel;
  logic [1:0] active_reference;
  logic converting;
  logic irq;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [7:0] rd;
  // ============================================================
  // device under test
  arr_top #(.CONV_CYCLES(CONV)) i_arr_top (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conversion_code, .active_channel,
    .active_reference, .converting, .irq
  );
  // ============================================================
  // clock, and a cycle ceiling so a hang still reports
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ============================================================
  // bus tasks: each channel released at the edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    s_axi_rready <= 1'b0;
  endtask
  // ============================================================
  // conversion helpers
  task automatic run_conv(input arr_code_t c);
    conversion_code <= c;
    axi_wr(A_CTRL, 8'hC0);
    for (n = 0; converting !== 1'b1 && n < 40; n++) @(posedge clk);
    for (n = 0; converting !== 1'b0 && n < 40; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK("conversion end", 1'b0, converting)
  endtask
  task automatic wait_irq();
    for (n = 0; irq !== 1'b1 && n < 60; n++) @(posedge clk);
    `CHK("irq", 1'b1, irq)
  endtask
  // low then high, as software must for a full result
  task automatic chk_bytes(input arr_code_t c, input logic la);
    arr_bytes_t e;
    e = la ? {c, 6'h00} : {6'h00, c};
    axi_rd(A_LO, rd);
    `CHK("low byte", e[7:0], rd)
    axi_rd(A_HI, rd);
    `CHK("high byte", e[15:8], rd)
  endtask
  // ============================================================
  // scenarios
  task automatic t_reset();
    chk_bytes(10'h000, 1'b0);
    axi_rd(8'h3C, rd);
    `CHK("unmapped", 8'h00, rd)
  endtask
  task automatic t_codes();
    arr_code_t codes[3] = '{10'h000, 10'h3FF, 10'h2B5};
    foreach (codes[i])
    begin
      axi_wr(A_CHAN, 8'h00);
      run_conv(codes[i]);
      chk_bytes(codes[i], 1'b0);
      axi_wr(A_CHAN, 8'h20);
      chk_bytes(codes[i], 1'b1);
    end
    axi_wr(A_LO, 8'hFF);
    axi_wr(A_HI, 8'hFF);
    chk_bytes(10'h2B5, 1'b1);
  endtask
  task automatic t_irq();
    axi_rd(A_IRQS, rd);
    axi_wr(A_MASK, 8'h00);
    run_conv(10'h111);
    `CHK("masked irq", 1'b0, irq)
    axi_rd(A_CTRL, rd);
    `CHK("done set", 1'b1, rd[4])
    axi_wr(A_CTRL, 8'h10);
    axi_rd(A_CTRL, rd);
    `CHK("done cleared", 1'b0, rd[4])
    axi_wr(A_MASK, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("unmasked irq", 1'b1, irq)
    axi_rd(A_IRQS, rd);
    `CHK("irq status", 1'b1, rd[0])
    repeat (2) @(posedge clk);
    `CHK("irq after read", 1'b0, irq)
  endtask
  task automatic t_lock();
    axi_wr(A_CHAN, 8'h00);
    run_conv(10'h155);
    axi_rd(A_IRQS, rd);
    axi_rd(A_LO, rd);
    `CHK("locked low", 8'h55, rd)
    run_conv(10'h2AA);
    `CHK("dropped irq", 1'b0, irq)
    axi_rd(A_HI, rd);
    `CHK("locked high", 8'h01, rd)
    axi_rd(A_LO, rd);
    `CHK("kept low", 8'h55, rd)
    axi_rd(A_HI, rd);
    axi_wr(A_CHAN, 8'h20);
    run_conv(10'h3C3);
    axi_rd(A_HI, rd);
    `CHK("high only", 8'hF0, rd)
    run_conv(10'h0FF);
    axi_rd(A_HI, rd);
    `CHK("high not locked", 8'h3F, rd)
    axi_rd(A_IRQS, rd);
  endtask
  // free-running scan: writes land mid conversion and just after completion
  task automatic t_free();
    axi_wr(A_CHAN, 8'h41);
    axi_wr(A_CTRL, 8'hE0);
    for (n = 0; converting !== 1'b1 && n < 40; n++) @(posedge clk);
    `CHK("first channel", 3'h1, active_channel)
    `CHK("first reference", 2'h1, active_reference)
    axi_wr(A_CHAN, 8'h82);
    `CHK("mid change held", 3'h1, active_channel)
    wait_irq();
    axi_wr(A_CHAN, 8'hC3);
    `CHK("late change held", 3'h2, active_channel)
    `CHK("second reference", 2'h2, active_reference)
    axi_rd(A_IRQS, rd);
    wait_irq();
    `CHK("third channel", 3'h3, active_channel)
    axi_wr(A_CTRL, 8'h80);
    for (n = 0; converting !== 1'b0 && n < 60; n++) @(posedge clk);
    axi_rd(A_IRQS, rd);
    `CHK("scan stopped", 1'b0, converting)
  endtask
  // ============================================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    conversion_code = 10'h000;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_codes();
    t_irq();
    t_lock();
    t_free();
    complete_run();
  end
endmodule
bind arr_top arr_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clk, .sys_rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .active_channel, .active_reference, .converting
);
`default_nettype wire
